// *** rtl/sbs_seq.sv ***
/*
 brake and stop sequencer: brake-hold timing at servo-off, stop method select,
 output terminal mapping with or-combining, small register port.
 assumes synchronous inputs, one clock, speed in r/min as unsigned magnitude.
*/
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
// Operation
// - by default brake asserts the instant servo-on drops while stopped
// - stopped: motor de-energize delayed 0..500 ticks after brake, default 0
// - alarm de-energizes motor at once, ignoring the delay
// - brake speed threshold 0..6000 r/min, default 100
// - rotating wait timeout 10..100 ticks, default 50
// - rotating: brake once speed falls below threshold
// - rotating: brake when wait timeout elapses, whichever first
// - brake-hold output high engages the brake
// - functions sharing one terminal are or-combined
// - threshold clipped to the motor maximum speed
// - stop digit 0 decelerates then coasts, 1 coasts
// - stop method applied at servo-off only; power loss uses decelerating stop
// - main or control power loss forces decelerating stop
// - alarm forces coasting stop
// - stop torque 0..300 percent, default 300
// - brake-hold drives no terminal until assigned, default unassigned
module sbs_seq #(
    parameter int TICK_CYCLES = sbs_pkg::TICK_CYCLES,
    parameter int TERMS = 6
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic [3:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    // drive status
    input wire logic servo_on_in,
    input wire logic alarm_in,
    input wire logic main_pwr_ok_in,
    input wire logic ctrl_pwr_ok_in,
    input wire logic [15:0] speed_in,
    input wire logic [TERMS-1:0] other_func_in,
    // drive commands
    output logic energize_out,
    output logic [1:0] stop_mode_out,
    output logic [15:0] stop_torque_out,
    output logic brake_hold_output_out,
    output logic [TERMS-1:0] term_out
);
    logic [15:0] delay_q, delay_d, spd_q, spd_d, wait_q, wait_d;
    logic [15:0] trq_q, trq_d, maxspd_q, maxspd_d;
    logic stop_sel_q, stop_sel_d;
    logic [2:0] term_sel_q, term_sel_d;
    logic [15:0] rdata_d;
    sbs_pkg::sbs_state_t st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic son_q;
    logic tick;
    logic tick_clr;
    logic [15:0] thr;
    logic pwr_off;
    logic brake_d, en_d;
    logic [1:0] mode_d;
    logic [TERMS-1:0] term_d;

    // clamp helper
    function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // register file, writes other than ctrl and max speed clipped into range
    always_comb
    begin
        delay_d = delay_q;
        spd_d = spd_q;
        wait_d = wait_q;
        trq_d = trq_q;
        maxspd_d = maxspd_q;
        stop_sel_d = stop_sel_q;
        term_sel_d = term_sel_q;
        rdata_d = 16'h0000;
        if (wr_in)
        begin
            unique case (addr_in)
                sbs_pkg::ADDR_CTRL:
                begin
                    stop_sel_d = wdata_in[sbs_pkg::CTRL_STOP_BIT];
                    term_sel_d = wdata_in[sbs_pkg::CTRL_TERM_LSB +: sbs_pkg::CTRL_TERM_W];
                end
                sbs_pkg::ADDR_ON_DELAY: delay_d = clip(wdata_in, 16'h0000, sbs_pkg::DELAY_MAX);
                sbs_pkg::ADDR_SPD_LVL: spd_d = clip(wdata_in, 16'h0000, sbs_pkg::SPD_MAX);
                sbs_pkg::ADDR_WAIT: wait_d = clip(wdata_in, sbs_pkg::WAIT_MIN, sbs_pkg::WAIT_MAX);
                sbs_pkg::ADDR_STOP_TRQ: trq_d = clip(wdata_in, 16'h0000, sbs_pkg::TRQ_MAX);
                sbs_pkg::ADDR_MAX_SPD: maxspd_d = wdata_in;
                default: ;
            endcase
        end
        if (rd_in)
        begin
            unique case (addr_in)
                sbs_pkg::ADDR_CTRL:
                    rdata_d = {9'h000, term_sel_q, 3'h0, stop_sel_q};
                sbs_pkg::ADDR_ON_DELAY: rdata_d = delay_q;
                sbs_pkg::ADDR_SPD_LVL: rdata_d = spd_q;
                sbs_pkg::ADDR_WAIT: rdata_d = wait_q;
                sbs_pkg::ADDR_STOP_TRQ: rdata_d = trq_q;
                sbs_pkg::ADDR_MAX_SPD: rdata_d = maxspd_q;
                sbs_pkg::ADDR_STATUS:
                    rdata_d = {11'h000, stop_mode_out, energize_out, brake_hold_output_out,
                               son_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            delay_q <= sbs_pkg::DELAY_RST;
            spd_q <= sbs_pkg::SPD_RST;
            wait_q <= sbs_pkg::WAIT_RST;
            trq_q <= sbs_pkg::TRQ_RST;
            maxspd_q <= sbs_pkg::MAXSPD_RST;
            stop_sel_q <= sbs_pkg::STOP_DECEL;
            term_sel_q <= sbs_pkg::TERM_NONE;
            rdata_out <= 16'h0000;
        end
        else
        begin
            delay_q <= delay_d;
            spd_q <= spd_d;
            wait_q <= wait_d;
            trq_q <= trq_d;
            maxspd_q <= maxspd_d;
            stop_sel_q <= stop_sel_d;
            term_sel_q <= term_sel_d;
            rdata_out <= rdata_d;
        end
    end

    // tick, restarted at servo-off
    assign tick_clr = (st_q == sbs_pkg::SBS_RUN);

    sbs_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .clear_in(tick_clr),
        .tick_out(tick)
    );

    assign thr = (spd_q > maxspd_q) ? maxspd_q : spd_q;
    assign pwr_off = !main_pwr_ok_in || !ctrl_pwr_ok_in;

    // brake and energize sequence
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (tick)
        begin
            cnt_d = cnt_q + 16'h0001;
        end
        unique case (st_q)
            sbs_pkg::SBS_RUN:
            begin
                if (alarm_in)
                begin
                    st_d = sbs_pkg::SBS_OFF;
                end
                else if (!servo_on_in || pwr_off)
                begin
                    cnt_d = 16'h0000;
                    if (speed_in < thr)
                    begin
                        st_d = (delay_q == 16'h0000) ? sbs_pkg::SBS_OFF : sbs_pkg::SBS_DELAY;
                    end
                    else
                    begin
                        st_d = sbs_pkg::SBS_SPIN;
                    end
                end
            end
            sbs_pkg::SBS_DELAY:
            begin
                if (alarm_in || cnt_d >= delay_q)
                begin
                    st_d = sbs_pkg::SBS_OFF;
                end
            end
            sbs_pkg::SBS_SPIN:
            begin
                if (alarm_in || speed_in < thr || cnt_d >= wait_q)
                begin
                    st_d = sbs_pkg::SBS_OFF;
                end
            end
            sbs_pkg::SBS_OFF:
            begin
                if (servo_on_in && !alarm_in && !pwr_off)
                begin
                    st_d = sbs_pkg::SBS_RUN;
                end
            end
        endcase
    end

    // brake and energize derived from next state, stop mode from the inputs
    always_comb
    begin
        brake_d = (st_d != sbs_pkg::SBS_RUN) && (st_d != sbs_pkg::SBS_SPIN);
        en_d = (st_d == sbs_pkg::SBS_RUN) || (st_d == sbs_pkg::SBS_DELAY);
        if (alarm_in)
        begin
            en_d = 1'b0;
            mode_d = sbs_pkg::SBS_STOP_COAST;
        end
        else if (pwr_off)
        begin
            en_d = 1'b0;
            mode_d = sbs_pkg::SBS_STOP_DECEL;
        end
        else if (!servo_on_in)
        begin
            mode_d = (stop_sel_q == sbs_pkg::STOP_COAST) ? sbs_pkg::SBS_STOP_COAST
                                                        : sbs_pkg::SBS_STOP_DECEL;
        end
        else
        begin
            mode_d = sbs_pkg::SBS_STOP_NONE;
        end
    end

    // terminal mapping
    for (genvar i = 0; i < TERMS; i++)
    begin : g_term
        assign term_d[i] = other_func_in[i] |
                           (brake_d && term_sel_q == 3'(i + 1));
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= sbs_pkg::SBS_OFF;
            cnt_q <= 16'h0000;
            son_q <= 1'b0;
            energize_out <= 1'b0;
            stop_mode_out <= sbs_pkg::SBS_STOP_NONE;
            stop_torque_out <= sbs_pkg::TRQ_RST;
            brake_hold_output_out <= 1'b1;
            term_out <= '0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            son_q <= servo_on_in;
            energize_out <= en_d;
            stop_mode_out <= mode_d;
            stop_torque_out <= trq_q;
            brake_hold_output_out <= brake_d;
            term_out <= term_d;
        end
    end

    AST_ALARM_OFF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        alarm_in |=> !energize_out && stop_mode_out == sbs_pkg::SBS_STOP_COAST)
        else $error("alarm did not de-energize with coast");
    AST_PWR_DECEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (pwr_off && !alarm_in) |=> stop_mode_out == sbs_pkg::SBS_STOP_DECEL)
        else $error("power loss did not force decel");
    AST_STOP_SEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (!servo_on_in && !pwr_off && !alarm_in) |=>
        stop_mode_out == ($past(stop_sel_q) ? sbs_pkg::SBS_STOP_COAST
                                            : sbs_pkg::SBS_STOP_DECEL))
        else $error("stop method mismatch");
    AST_BRAKE_IMMED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (st_q == sbs_pkg::SBS_RUN && !servo_on_in && speed_in < thr) |=>
        brake_hold_output_out)
        else $error("brake late while stopped");
    AST_SPIN_SLOW: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (st_q == sbs_pkg::SBS_SPIN && speed_in < thr) |=> brake_hold_output_out)
        else $error("brake missed on low speed");
    AST_SPIN_TIMEOUT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (st_q == sbs_pkg::SBS_SPIN) |-> cnt_q <= wait_q)
        else $error("wait timeout exceeded");
    AST_DELAY_EN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (st_q == sbs_pkg::SBS_DELAY && !alarm_in && !pwr_off) |-> brake_hold_output_out
        && energize_out)
        else $error("delay state outputs wrong");
    AST_THR_CLIP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        thr <= maxspd_q && thr <= spd_q)
        else $error("threshold not clipped");
    AST_TERM_NONE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (term_sel_q == sbs_pkg::TERM_NONE) |=> term_out == $past(other_func_in))
        else $error("unassigned brake drove terminal");
    AST_LIMITS: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        delay_q <= sbs_pkg::DELAY_MAX && wait_q >= sbs_pkg::WAIT_MIN
        && trq_q <= sbs_pkg::TRQ_MAX)
        else $error("parameter out of range");

    COV_SPIN: cover property (@(posedge mclk_in) st_q == sbs_pkg::SBS_SPIN ##1 st_q == sbs_pkg::SBS_OFF);
    COV_DELAY: cover property (@(posedge mclk_in) st_q == sbs_pkg::SBS_DELAY ##1 st_q == sbs_pkg::SBS_OFF);
    COV_ALARM: cover property (@(posedge mclk_in) alarm_in && st_q == sbs_pkg::SBS_RUN);
endmodule

// *** common/sbs_pkg.sv ***
/*
 package for the servo brake stop sequencer: parameter defaults, codes, timing.
 assumes a single 125 MHz clock domain.
*/
package sbs_pkg;
    // clock and tick timing
    localparam int CLK_HZ = 125_000_000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_ON_DELAY = 4'h1;
    localparam logic [3:0] ADDR_SPD_LVL = 4'h2;
    localparam logic [3:0] ADDR_WAIT = 4'h3;
    localparam logic [3:0] ADDR_STOP_TRQ = 4'h4;
    localparam logic [3:0] ADDR_MAX_SPD = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    // ctrl fields
    localparam int CTRL_STOP_BIT = 0;
    localparam int CTRL_TERM_LSB = 4;
    localparam int CTRL_TERM_W = 3;
    // ranges and defaults
    localparam logic [15:0] DELAY_MAX = 16'h01F4;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [15:0] SPD_MAX = 16'h1770;
    localparam logic [15:0] SPD_RST = 16'h0064;
    localparam logic [15:0] WAIT_MIN = 16'h000A;
    localparam logic [15:0] WAIT_MAX = 16'h0064;
    localparam logic [15:0] WAIT_RST = 16'h0032;
    localparam logic [15:0] TRQ_MAX = 16'h012C;
    localparam logic [15:0] TRQ_RST = 16'h012C;
    localparam logic [15:0] MAXSPD_RST = 16'h1770;
    localparam logic [2:0] TERM_NONE = 3'h0;
    // stop method codes
    localparam logic STOP_DECEL = 1'b0;
    localparam logic STOP_COAST = 1'b1;
    typedef enum logic [1:0] {SBS_STOP_NONE, SBS_STOP_DECEL, SBS_STOP_COAST} sbs_stop_t;
    typedef enum {SBS_RUN, SBS_DELAY, SBS_SPIN, SBS_OFF} sbs_state_t;
endpackage

// *** rtl/sbs_tick.sv ***
/*
 10 ms tick generator from the system clock.
 assumes mclk_in at the package clock rate.
*/
`timescale 1ns/1ps
module sbs_tick #(
    parameter int CYCLES = sbs_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // restart and tick
    input wire logic clear_in,
    output logic tick_out
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;

    always_comb
    begin
        tick_d = 1'b0;
        cnt_d = cnt_q + 32'h0000_0001;
        if (clear_in)
        begin
            cnt_d = 32'h0000_0000;
        end
        else if (cnt_q == 32'(CYCLES - 1))
        begin
            cnt_d = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_q <= 32'h0000_0000;
            tick_out <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_out <= tick_d;
        end
    end
endmodule

// *** bench/sbs_motor.sv ***
/*
 motor and brake relay model for the brake stop sequencer bench.
 assumes one clock; speed follows the command while energized.
*/
`timescale 1ns/1ps
module sbs_motor (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // drive side
    input wire logic energize_in,
    input wire logic brake_in,
    input wire logic [15:0] cmd_speed_in,
    // motor speed
    output logic [15:0] speed_out
);
    logic [15:0] speed_d;
    logic [15:0] speed_q;
    always_comb
    begin
        if (energize_in)
            speed_d = cmd_speed_in;
        else if (brake_in)
            speed_d = 16'h0000;
        else
            speed_d = speed_q - (speed_q >> 3);
    end
    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            speed_q <= 16'h0000;
        else
            speed_q <= speed_d;
    end
    assign speed_out = speed_q;
endmodule

// *** bench/testbench.sv ***
/*
 self-checking bench for the brake stop sequencer with a motor model.
 assumes a 10-cycle tick and six output terminals.
*/
`timescale 1ns/1ps
module testbench;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic servo_on_in = 1'b0;
    logic alarm_in = 1'b0;
    logic main_pwr_ok_in = 1'b1;
    logic ctrl_pwr_ok_in = 1'b1;
    logic [5:0] other_func_in = 6'h00;
    logic [15:0] cmd_speed = 16'h0000;
    logic [15:0] speed;
    logic [15:0] rdata_out;
    logic energize_out;
    logic [1:0] stop_mode_out;
    logic [15:0] stop_torque_out;
    logic brake_hold_output_out;
    logic [5:0] term_out;
    int n_errors = 0;
    int cmp_count = 0;
    logic [15:0] r;
    logic [15:0] v;
    logic [15:0] lo [1:4] = '{16'h0000, 16'h0000, sbs_pkg::WAIT_MIN, 16'h0000};
    logic [15:0] hi [1:4] = '{sbs_pkg::DELAY_MAX, sbs_pkg::SPD_MAX, sbs_pkg::WAIT_MAX,
        sbs_pkg::TRQ_MAX};
    logic [15:0] dflt [1:5] = '{sbs_pkg::DELAY_RST, sbs_pkg::SPD_RST, sbs_pkg::WAIT_RST,
        sbs_pkg::TRQ_RST, sbs_pkg::MAXSPD_RST};
    localparam logic [15:0] DEC = 16'(sbs_pkg::SBS_STOP_DECEL);
    localparam logic [15:0] CST = 16'(sbs_pkg::SBS_STOP_COAST);

    always #4 mclk_in = ~mclk_in;

    sbs_seq #(.TICK_CYCLES(10), .TERMS(6)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .servo_on_in(servo_on_in), .alarm_in(alarm_in),
        .main_pwr_ok_in(main_pwr_ok_in), .ctrl_pwr_ok_in(ctrl_pwr_ok_in), .speed_in(speed),
        .other_func_in(other_func_in), .energize_out(energize_out),
        .stop_mode_out(stop_mode_out), .stop_torque_out(stop_torque_out),
        .brake_hold_output_out(brake_hold_output_out), .term_out(term_out));

    sbs_motor motor (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .energize_in(energize_out),
        .brake_in(brake_hold_output_out), .cmd_speed_in(cmd_speed), .speed_out(speed));

    function automatic logic [15:0] clip(input logic [15:0] x, input logic [15:0] l,
        input logic [15:0] h);
        return (x < l) ? l : ((x > h) ? h : x);
    endfunction

    task automatic give_verdict();
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        q = rdata_out;
    endtask

    task automatic son(input logic s);
        @(posedge mclk_in);
        servo_on_in <= s;
    endtask

    // servo on with a commanded speed, then servo off
    task automatic run_off(input logic [15:0] s);
        cmd_speed <= s;
        son(1'b1);
        cyc(4);
        son(1'b0);
    endtask

    initial
    begin
        #(20000 * 8);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        v = $urandom(13768);
        cyc(5);
        chk("brake_rst", 16'h0001, 16'(brake_hold_output_out));
        chk("energize_rst", 16'h0000, 16'(energize_out));
        @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (int a = 1; a <= 5; a++)
        begin
            rd(4'(a), r);
            chk("reg_default", dflt[a], r);
        end
        rd(4'h7, r);
        chk("unmapped", 16'h0000, r);
        for (int a = 1; a <= 4; a++)
            for (int k = 0; k < 3; k++)
            begin
                v = (k == 0) ? 16'h0000 : ((k == 1) ? 16'hFFFF : 16'($urandom_range(0, 7000)));
                wr(4'(a), v);
                rd(4'(a), r);
                chk("reg_clip", clip(v, lo[a], hi[a]), r);
            end
        chk("torque_out", clip(v, lo[4], hi[4]), stop_torque_out);
        for (int a = 1; a <= 4; a++)
            wr(4'(a), dflt[a]);
        // stopped, no delay
        run_off(16'h0000);
        cyc(2);
        chk("brake_stop", 16'h0001, 16'(brake_hold_output_out));
        chk("energize_stop", 16'h0000, 16'(energize_out));
        chk("mode_stop", DEC, 16'(stop_mode_out));
        rd(4'h6, r);
        chk("status_stop", {11'h000, DEC[1:0], 1'b0, 1'b1, 1'b0}, r);
        other_func_in <= 6'($urandom());
        cyc(3);
        chk("term_none", 16'(other_func_in), 16'(term_out));
        for (int t = 1; t <= 6; t++)
        begin
            wr(4'(t << 4), 16'(t << 4));
            other_func_in <= 6'($urandom());
            cyc(3);
            chk("term_or", 16'(other_func_in | (6'h01 << (t - 1))), 16'(term_out));
        end
        wr(4'h0, 16'h0000);
        // stopped, delay of three ticks
        wr(4'h1, 16'h0003);
        run_off(16'h0000);
        cyc(2);
        chk("brake_delay", 16'h0001, 16'(brake_hold_output_out));
        cyc(20);
        chk("energize_hold", 16'h0001, 16'(energize_out));
        cyc(20);
        chk("energize_late", 16'h0000, 16'(energize_out));
        // alarm inside the delay
        run_off(16'h0000);
        cyc(3);
        alarm_in <= 1'b1;
        cyc(2);
        chk("energize_alarm", 16'h0000, 16'(energize_out));
        chk("mode_alarm", CST, 16'(stop_mode_out));
        alarm_in <= 1'b0;
        wr(4'h1, 16'h0000);
        // rotating, threshold clipped to motor maximum
        wr(4'h5, 16'h01F4);
        wr(4'h2, 16'h1770);
        run_off(16'h03E8);
        cyc(6);
        chk("brake_spin", 16'h0000, 16'(brake_hold_output_out));
        cmd_speed <= 16'h0190;
        cyc(5);
        chk("brake_slow", 16'h0001, 16'(brake_hold_output_out));
        wr(4'h5, sbs_pkg::MAXSPD_RST);
        // rotating, wait timeout of ten ticks, threshold zero so only the timeout acts
        wr(4'h2, 16'h0000);
        wr(4'h3, 16'h000A);
        run_off(16'h03E8);
        cyc(90);
        chk("brake_wait", 16'h0000, 16'(brake_hold_output_out));
        cyc(20);
        chk("brake_tmo", 16'h0001, 16'(brake_hold_output_out));
        chk("energize_tmo", 16'h0000, 16'(energize_out));
        wr(4'h2, sbs_pkg::SPD_RST);
        // coast digit, then power loss overriding it
        wr(4'h0, 16'h0001);
        run_off(16'h0000);
        cyc(2);
        chk("mode_coast", CST, 16'(stop_mode_out));
        for (int p = 0; p < 2; p++)
        begin
            son(1'b1);
            cyc(4);
            if (p == 0)
                main_pwr_ok_in <= 1'b0;
            else
                ctrl_pwr_ok_in <= 1'b0;
            cyc(3);
            chk("energize_pwr", 16'h0000, 16'(energize_out));
            chk("mode_pwr", DEC, 16'(stop_mode_out));
            main_pwr_ok_in <= 1'b1;
            ctrl_pwr_ok_in <= 1'b1;
            son(1'b0);
        end
        wr(4'h0, 16'h0000);
        // random speeds around the default threshold
        wr(4'h3, sbs_pkg::WAIT_RST);
        for (int i = 0; i < 8; i++)
        begin
            v = 16'($urandom_range(0, 200));
            run_off(v);
            cyc(2);
            chk("brake_rand", 16'(v < sbs_pkg::SPD_RST), 16'(brake_hold_output_out));
            cmd_speed <= 16'h0000;
            cyc(12);
            chk("brake_rand_end", 16'h0001, 16'(brake_hold_output_out));
        end
        give_verdict();
    end
endmodule
